// ===== tac_dev_end.sv
// converter end: control word capture, acquisition, conversion and power
// Behaviour
// - battery divider on only while sampling channel 010
// - host frames transfers as three bytes, total 24 clocks
// - first eight clocks carry control word in
// - acquire after mux bits, hold three clocks later
// - result spans twelve clocks (eight in 8-bit mode) after acquisition
// - differential mode keeps drivers on through conversion
// - trailing clocks ignored, serial output low
// - nothing taken before a high start bit
// - msb first: start, channel, mode, reference, power
// - channel and reference bit set mux, switches
// - mode bit low twelve bits, high eight
// - new word every 15th or 11th clock
// - reference bit high single-ended, low differential
// - host uses differential only on touch channels
// - reference power apart; converter needs no wake-up
// - reference state latched as busy rises
// - 00 sleeps between conversions, pen on, y minus
// - 01 reference off, converter on, pen off
// - 10 reference on, converter off, pen on
// - 11 all powered, pen off
// - host adds no reference settling time between conversions
// - pen detection returns after bit one leaves
// - disabled pen output low touch, high others
`timescale 1ns/1ps
module tac_dev_end (
    // link
    tac_link_if.dev_mp             LNK,
    // reset
    input  wire logic              RST_N,
    // analog front end
    input  wire logic [11:0]       SAMPLE_VALUE,
    input  wire logic              PEN_TOUCH,
    output wire logic [2:0]        MUX_SEL,
    output wire logic [3:0]        DRV_SW,
    output wire logic              REF_DIFF,
    output wire logic              BAT_DIV_EN,
    output wire logic              SAMPLE_HOLD,
    // power state
    output wire logic              REF_ON,
    output wire logic              ADC_ON
);

    // ------------------------------------------------------------
    // word capture on rising edges
    // ------------------------------------------------------------
    logic [4:0]  cnt_r;        // clocks since start bit
    logic [7:0]  ctrl_r;       // control word shifter
    logic [4:0]  cnt_nxt;      // next count
    logic [7:0]  ctrl_nxt;     // next shifter
    logic        pen_s1_r;     // touch sync, first stage
    logic        pen_s2_r;     // touch sync, second stage
    logic [11:0] smp_s1_r;     // sample sync, first stage
    logic [11:0] smp_s2_r;     // sample sync, second stage

    wire [4:0] lim      = ctrl_r[tac_pkg::MODE_BIT] ? tac_pkg::LIM8 : tac_pkg::LIM12;
    wire       start_ok = (cnt_r == tac_pkg::CNT_ZERO) || (cnt_r >= lim);
    wire       start    = start_ok && LNK.din;
    wire       shifting = (cnt_r != tac_pkg::CNT_ZERO) && (cnt_r < tac_pkg::CNT_BYTE);

    // count selection: frame end, start, advance, hold
    assign cnt_nxt  = LNK.cs_n ? tac_pkg::CNT_ZERO :
                      start ? tac_pkg::CNT_START :
                      (cnt_r != tac_pkg::CNT_ZERO && cnt_r != tac_pkg::CNT_MAX) ? 5'(cnt_r + 5'h01) :
                      cnt_r;
    // msb-first word assembly, start bit seeds the shifter
    assign ctrl_nxt = (start && !LNK.cs_n) ? 8'h01 :
                      (shifting && !LNK.cs_n) ? {ctrl_r[6:0], LNK.din} :
                      ctrl_r;

    // rising-edge capture of serial input
    always_ff @(posedge LNK.sclk or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r  <= tac_pkg::CNT_ZERO;
            ctrl_r <= 8'h00;
        end else begin
            cnt_r  <= cnt_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // synchronisers for front-end levels
    always_ff @(posedge LNK.sclk or negedge RST_N) begin
        if (!RST_N) begin
            pen_s1_r <= 1'b0;
            pen_s2_r <= 1'b0;
            smp_s1_r <= 12'h000;
            smp_s2_r <= 12'h000;
        end else begin
            pen_s1_r <= PEN_TOUCH;
            pen_s2_r <= pen_s1_r;
            smp_s1_r <= SAMPLE_VALUE;
            smp_s2_r <= smp_s1_r;
        end
    end

    // ------------------------------------------------------------
    // sequence events seen on falling edges
    // ------------------------------------------------------------
    logic [3:0]  left_r;       // result bits still to send
    logic [11:0] shf_r;        // result shifter
    logic [1:0]  pd_r;         // power select of current conversion

    wire       e_acq    = cnt_r == tac_pkg::CNT_ACQ;
    wire       e_ref    = cnt_r == tac_pkg::CNT_REF;
    wire       e_byte   = cnt_r == tac_pkg::CNT_BYTE;
    wire       e_end    = (left_r == tac_pkg::LEFT_LAST) && !e_byte;
    wire [2:0] acq_chan = ctrl_r[tac_pkg::CHAN_HI - tac_pkg::ACQ_SHIFT -: 3];
    wire       sleep_pd = !pd_r[tac_pkg::PD_LO];           // pen on when low

    // ------------------------------------------------------------
    // front end: switches, divider, hold, power
    // ------------------------------------------------------------
    logic [2:0] chan_r;
    logic       ser_r;
    logic       diff_r;      // registered differential flag for the pin
    logic [3:0] drv_r;
    logic       bat_r;
    logic       hold_r;
    logic       pen_en_r;
    logic       adc_r;
    logic       ref_r;
    logic [2:0] chan_nxt;
    logic       ser_nxt;
    logic [3:0] drv_nxt;
    logic       bat_nxt;
    logic       hold_nxt;
    logic       pen_en_nxt;
    logic       adc_nxt;
    logic       ref_nxt;
    logic [1:0] pd_nxt;

    assign chan_nxt   = e_acq ? acq_chan : chan_r;
    assign ser_nxt    = e_ref ? ctrl_r[tac_pkg::REF_BIT - tac_pkg::REF_SHIFT] : ser_r;
    // acquisition wins over the end of an overlapped conversion
    assign drv_nxt    = e_acq ? tac_pkg::drv_for(acq_chan) :
                        (e_byte && ser_r) ? tac_pkg::DRV_NONE :
                        e_end ? (sleep_pd ? tac_pkg::DRV_YN : tac_pkg::DRV_NONE) :
                        drv_r;
    assign bat_nxt    = e_acq ? (acq_chan == tac_pkg::CH_BAT) :
                        e_byte ? 1'b0 : bat_r;
    assign hold_nxt   = e_acq ? 1'b0 : e_byte ? 1'b1 : hold_r;
    assign pen_en_nxt = e_acq ? 1'b0 : e_end ? sleep_pd : pen_en_r;
    assign adc_nxt    = e_acq ? 1'b1 :
                        e_end ? pd_r[tac_pkg::PD_LO] : adc_r;
    assign ref_nxt    = e_byte ? ctrl_r[tac_pkg::PD_HI] : ref_r;
    assign pd_nxt     = e_byte ? ctrl_r[tac_pkg::PD_HI:tac_pkg::PD_LO] : pd_r;

    // front-end state, updated on falling edges
    always_ff @(negedge LNK.sclk or negedge RST_N) begin
        if (!RST_N) begin
            chan_r   <= 3'h0;
            ser_r    <= 1'b1;
            diff_r   <= 1'b0;
            drv_r    <= tac_pkg::DRV_YN;
            bat_r    <= 1'b0;
            hold_r   <= 1'b0;
            pen_en_r <= 1'b1;
            adc_r    <= 1'b0;
            ref_r    <= 1'b0;
            pd_r     <= 2'h0;
        end else begin
            chan_r   <= chan_nxt;
            ser_r    <= ser_nxt;
            diff_r   <= !ser_nxt;
            drv_r    <= drv_nxt;
            bat_r    <= bat_nxt;
            hold_r   <= hold_nxt;
            pen_en_r <= pen_en_nxt;
            adc_r    <= adc_nxt;
            ref_r    <= ref_nxt;
            pd_r     <= pd_nxt;
        end
    end

    // ------------------------------------------------------------
    // result shifting on falling edges
    // ------------------------------------------------------------
    logic        dout_r;
    logic        busy_r;
    logic [3:0]  left_nxt;
    logic [11:0] shf_nxt;
    logic        dout_nxt;

    wire sending = (left_r != 4'h0) && !e_byte;
    assign left_nxt = e_byte ? (ctrl_r[tac_pkg::MODE_BIT] ? tac_pkg::BITS8 : tac_pkg::BITS12) :
                      sending ? 4'(left_r - 4'h1) : left_r;
    assign shf_nxt  = e_byte ? smp_s2_r : sending ? {shf_r[10:0], 1'b0} : shf_r;
    // low once the result is out, so trailing clocks see zeros
    assign dout_nxt = sending ? shf_r[tac_pkg::RES_W - 1] : 1'b0;

    always_ff @(negedge LNK.sclk or negedge RST_N) begin
        if (!RST_N) begin
            left_r <= 4'h0;
            shf_r  <= 12'h000;
            dout_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            left_r <= left_nxt;
            shf_r  <= shf_nxt;
            dout_r <= dout_nxt;
            busy_r <= e_byte;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic out_oe_r;    // output enable, dropped at once by frame end
    logic pen_n_r;     // pen interrupt pin

    // enable drops with the frame select at once, rises on the next falling clock
    always_ff @(negedge LNK.sclk or posedge LNK.cs_n or negedge RST_N) begin
        if (!RST_N) begin
            out_oe_r <= 1'b0;
        end else if (LNK.cs_n) begin
            out_oe_r <= 1'b0;
        end else begin
            out_oe_r <= 1'b1;
        end
    end

    // touch level while enabled, fixed level per channel otherwise
    always_ff @(negedge LNK.sclk or negedge RST_N) begin
        if (!RST_N) begin
            pen_n_r <= 1'b1;
        end else begin
            pen_n_r <= pen_en_r ? !pen_s2_r : !tac_pkg::is_touch(chan_r);
        end
    end

    assign LNK.dout      = dout_r;
    assign LNK.busy      = busy_r;
    assign LNK.dout_oe   = out_oe_r;
    assign LNK.pen_irq_n = pen_n_r;
    assign MUX_SEL       = chan_r;
    assign DRV_SW        = drv_r;
    assign REF_DIFF      = diff_r;
    assign BAT_DIV_EN    = bat_r;
    assign SAMPLE_HOLD   = hold_r;
    assign REF_ON        = ref_r;
    assign ADC_ON        = adc_r;

endmodule : tac_dev_end

// ===== tac_host_end.sv
// host end: frames 24-clock transfers and collects the result
`timescale 1ns/1ps
module tac_host_end (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // link
    tac_link_if.hst_mp       LNK,
    // command
    input  wire logic        CMD_VALID,
    input  wire logic [7:0]  CMD_WORD,
    output wire logic        CMD_READY,
    // result
    output wire logic        RES_VALID,
    output wire logic [11:0] RES_DATA,
    output wire logic        PEN_IRQ_N
);

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END} tac_hst_t;
    tac_hst_t    st_r;          // frame state
    logic [1:0]  ph_r;          // half-period counter
    logic [4:0]  k_r;           // serial clock number in frame
    logic [7:0]  word_r;        // outgoing word
    logic        mode_r;        // 8-bit result expected
    logic        sclk_r;
    logic        cs_n_r;
    logic        din_r;
    logic        rdy_r;
    logic        vld_r;
    logic [11:0] res_r;
    logic        dout_s1_r;     // result line sync
    logic        dout_s2_r;
    logic        pen_s1_r;      // pen line sync
    logic        pen_s2_r;

    // start bit forced, single-ended forced off the touch channels
    function automatic logic [7:0] fix_word(input logic [7:0] w);
        logic [7:0] f;
        f = w;
        f[tac_pkg::START_BIT] = 1'b1;
        if (!tac_pkg::is_touch(w[tac_pkg::CHAN_HI:tac_pkg::CHAN_LO])) begin
            f[tac_pkg::REF_BIT] = 1'b1;
        end
        fix_word = f;
    endfunction : fix_word

    wire       ph_last = ph_r == tac_pkg::PH_LAST;
    wire [4:0] res_end = mode_r ? tac_pkg::RES_END8 : tac_pkg::RES_END12;
    wire       take    = (k_r >= tac_pkg::RES_FIRST) && (k_r < res_end);

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            dout_s1_r <= 1'b0;
            dout_s2_r <= 1'b0;
            pen_s1_r  <= 1'b1;
            pen_s2_r  <= 1'b1;
        end else begin
            dout_s1_r <= LNK.dout;
            dout_s2_r <= dout_s1_r;
            pen_s1_r  <= LNK.pen_irq_n;
            pen_s2_r  <= pen_s1_r;
        end
    end

    // ------------------------------------------------------------
    // frame sequencer, serial clock made by dividing MCLK
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r   <= H_IDLE;
            ph_r   <= 2'h0;
            k_r    <= tac_pkg::CNT_ZERO;
            word_r <= 8'h00;
            mode_r <= 1'b0;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            din_r  <= 1'b0;
            rdy_r  <= 1'b1;
            vld_r  <= 1'b0;
            res_r  <= 12'h000;
        end else begin
            vld_r <= 1'b0;
            case (st_r)
                // accept a word and open the frame
                H_IDLE: begin
                    if (CMD_VALID) begin
                        word_r <= fix_word(CMD_WORD);
                        mode_r <= CMD_WORD[tac_pkg::MODE_BIT];
                        cs_n_r <= 1'b0;
                        rdy_r  <= 1'b0;
                        res_r  <= 12'h000;
                        k_r    <= tac_pkg::CNT_START;
                        st_r   <= H_SETUP;
                    end
                end
                // first bit set up ahead of the first rising edge
                H_SETUP: begin
                    din_r  <= word_r[tac_pkg::START_BIT];
                    word_r <= {word_r[6:0], 1'b0};
                    ph_r   <= 2'h0;
                    st_r   <= H_LOW;
                end
                // low half of a serial clock
                H_LOW: begin
                    if (ph_last) begin
                        sclk_r <= 1'b1;
                        ph_r   <= 2'h0;
                        st_r   <= H_HIGH;
                    end else begin
                        ph_r <= 2'(ph_r + 2'h1);
                    end
                end
                // high half: sample result late, then fall
                H_HIGH: begin
                    if (ph_last) begin
                        sclk_r <= 1'b0;
                        ph_r   <= 2'h0;
                        if (take) begin
                            res_r <= {res_r[10:0], dout_s2_r};
                        end
                        if (k_r == tac_pkg::FRAME_CLKS) begin
                            st_r <= H_END;
                        end else begin
                            k_r    <= 5'(k_r + 5'h01);
                            din_r  <= word_r[tac_pkg::START_BIT];
                            word_r <= {word_r[6:0], 1'b0};
                            st_r   <= H_LOW;
                        end
                    end else begin
                        ph_r <= 2'(ph_r + 2'h1);
                    end
                end
                // close the frame and hand back the result
                H_END: begin
                    cs_n_r <= 1'b1;
                    din_r  <= 1'b0;
                    vld_r  <= 1'b1;
                    rdy_r  <= 1'b1;
                    st_r   <= H_IDLE;
                end
                default: begin
                    st_r <= H_IDLE;
                end
            endcase
        end
    end

    assign LNK.sclk  = sclk_r;
    assign LNK.cs_n  = cs_n_r;
    assign LNK.din   = din_r;
    assign CMD_READY = rdy_r;
    assign RES_VALID = vld_r;
    assign RES_DATA  = res_r;
    assign PEN_IRQ_N = pen_s2_r;

endmodule : tac_host_end

// ===== tac_link_if.sv
// serial link between the converter end and the host end
`timescale 1ns/1ps
interface tac_link_if;
    logic sclk;       // serial_shift_clock, made by the host
    logic cs_n;       // frame select, active low
    logic din;        // control bits to the converter
    logic dout;       // result bits to the host
    logic dout_oe;    // converter drives dout and busy
    logic busy;       // conversion started
    logic pen_irq_n;  // pen_touch_interrupt, active low

    // converter end
    modport dev_mp (input sclk, input cs_n, input din,
                    output dout, output dout_oe, output busy, output pen_irq_n);
    // host end
    modport hst_mp (output sclk, output cs_n, output din,
                    input dout, input dout_oe, input busy, input pen_irq_n);
endinterface : tac_link_if

// ===== tac_pkg.sv
// shared constants and helpers for the touch converter serial link
package tac_pkg;

    // ------------------------------------------------------------
    // control word layout
    // ------------------------------------------------------------
    localparam int START_BIT = 7;          // start flag position
    localparam int CHAN_HI   = 6;          // channel select, top bit
    localparam int CHAN_LO   = 4;          // channel select, low bit
    localparam int MODE_BIT  = 3;          // resolution select
    localparam int REF_BIT   = 2;          // reference mode select
    localparam int PD_HI     = 1;          // power_down_select_high
    localparam int PD_LO     = 0;          // power_down_select_low
    localparam int RES_W     = 12;         // widest result

    // ------------------------------------------------------------
    // sequencing, in serial clocks counted from the start bit
    // ------------------------------------------------------------
    localparam logic [4:0] CNT_ZERO   = 5'h00;  // idle
    localparam logic [4:0] CNT_START  = 5'h01;  // start bit clock
    localparam logic [4:0] CNT_ACQ    = 5'h05;  // acquisition begins
    localparam logic [4:0] CNT_REF    = 5'h06;  // reference bit held
    localparam logic [4:0] CNT_BYTE   = 5'h08;  // word complete, hold
    localparam logic [4:0] CNT_MAX    = 5'h1f;  // counter saturates
    localparam logic [4:0] LIM12      = 5'h0f;  // restart spacing, 12 bit
    localparam logic [4:0] LIM8       = 5'h0b;  // restart spacing, 8 bit
    localparam logic [4:0] FRAME_CLKS = 5'h18;  // clocks in one frame
    localparam logic [4:0] RES_FIRST  = 5'h0a;  // clock carrying msb
    localparam logic [4:0] RES_END12  = 5'h16;  // one past lsb, 12 bit
    localparam logic [4:0] RES_END8   = 5'h12;  // one past lsb, 8 bit
    localparam logic [3:0] BITS12     = 4'hc;   // result bits, 12 bit
    localparam logic [3:0] BITS8      = 4'h8;   // result bits, 8 bit
    localparam logic [3:0] LEFT_LAST  = 4'h1;   // bit 0 goes out next
    localparam int ACQ_SHIFT = 3;               // CNT_BYTE - CNT_ACQ
    localparam int REF_SHIFT = 2;               // CNT_BYTE - CNT_REF

    // ------------------------------------------------------------
    // channel codes and switch patterns {xp, xn, yp, yn}
    // ------------------------------------------------------------
    localparam logic [2:0] CH_Y   = 3'h1;   // y position
    localparam logic [2:0] CH_BAT = 3'h2;   // battery_sense_input
    localparam logic [2:0] CH_Z1  = 3'h3;   // pressure 1
    localparam logic [2:0] CH_Z2  = 3'h4;   // pressure 2
    localparam logic [2:0] CH_X   = 3'h5;   // x position
    localparam logic [3:0] DRV_NONE = 4'h0; // all switches open
    localparam logic [3:0] DRV_YN   = 4'h1; // y minus only
    localparam logic [3:0] DRV_XPL  = 4'hc; // x plane driven
    localparam logic [3:0] DRV_YPL  = 4'h3; // y plane driven
    localparam logic [3:0] DRV_PRS  = 4'h6; // x minus and y plus

    // ------------------------------------------------------------
    // host timing
    // ------------------------------------------------------------
    localparam int MCLK_NS    = 100;        // host clock period
    localparam int SCLK_HI_NS = 200;        // least serial high/low
    localparam int HALF_CYC   = (SCLK_HI_NS + MCLK_NS - 1) / MCLK_NS;
    localparam logic [1:0] PH_LAST = 2'(HALF_CYC - 1);

    // channels measured across the panel
    function automatic logic is_touch(input logic [2:0] ch);
        is_touch = (ch == CH_X) || (ch == CH_Y) || (ch == CH_Z1) || (ch == CH_Z2);
    endfunction : is_touch

    // switch pattern for a channel
    function automatic logic [3:0] drv_for(input logic [2:0] ch);
        case (ch)
            CH_Y:         drv_for = DRV_XPL;
            CH_X:         drv_for = DRV_YPL;
            CH_Z1, CH_Z2: drv_for = DRV_PRS;
            default:      drv_for = DRV_NONE;
        endcase
    endfunction : drv_for

endpackage : tac_pkg

// ===== tac_sva.sv
// link checker: timing relations on the serial link between both ends
`timescale 1ns/1ps
module tac_sva (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic busy
);
    // ------------------------------------------------------------
    // helper: serial clock rises counted inside one frame
    // ------------------------------------------------------------
    logic [4:0] rise_cnt_r;   // rises since select went low
    logic [4:0] rise_cnt_nxt; // next count
    logic       sclk_q_r;     // serial clock one host cycle ago
    assign rise_cnt_nxt = cs_n ? 5'h00 : rise_cnt_r + 5'(sclk & ~sclk_q_r);
    // count register, cleared while no frame is open
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rise_cnt_r <= 5'h00;
            sclk_q_r   <= 1'b0;
        end else begin
            rise_cnt_r <= rise_cnt_nxt;
            sclk_q_r   <= sclk;
        end
    end
    // ------------------------------------------------------------
    // sequences: result line quiet after the last bit
    // ------------------------------------------------------------
    sequence s_quiet12; !dout [*3]; endsequence
    sequence s_quiet8; !dout [*7]; endsequence
    a_busy_pulse: assert property (@(posedge sclk) disable iff (!RST_N)
        $rose(busy) |=> !busy) else $error("busy not one clock wide");
    a_start_first: assert property (@(posedge sclk) disable iff (!RST_N)
        $rose(busy) |-> $past(din, 8)) else $error("busy without a start bit");
    a_trail_twelve: assert property (@(posedge sclk) disable iff (!RST_N)
        $rose(busy) && !$past(din, 4) |-> ##13 s_quiet12) else $error("output not low after 12-bit result");
    a_trail_eight: assert property (@(posedge sclk) disable iff (!RST_N)
        $rose(busy) && $past(din, 4) |-> ##9 s_quiet8) else $error("output not low after 8-bit result");
    a_frame_len: assert property (@(posedge MCLK) disable iff (!RST_N)
        $rose(cs_n) |-> rise_cnt_r == 5'h18) else $error("frame is not 24 clocks");
    a_sclk_idle: assert property (@(posedge MCLK) disable iff (!RST_N)
        cs_n |-> !sclk) else $error("serial clock runs outside a frame");
    a_oe_frame: assert property (@(posedge MCLK) disable iff (!RST_N)
        cs_n |-> !dout_oe && !busy) else $error("output enabled outside a frame");
    a_dout_fall: assert property (@(posedge MCLK) disable iff (!RST_N)
        $changed(dout) |-> $fell(sclk)) else $error("result bit moved off a falling edge");
endmodule : tac_sva

// ===== tb_touch_adc_serial_control.sv
// testbench: host end and converter end joined over the serial link
`timescale 1ns/1ps
module tb_touch_adc_serial_control;
    logic        MCLK, RST_N;               // clock and reset
    logic        touch, cmd_valid, res_valid; // stimulus and handshake
    logic        pen_irq_n, ref_diff, bat_en, ref_on, adc_on, bat_seen;
    logic        hold, cmd_ready;           // sample hold and host ready
    logic [7:0]  cmd_word, w;               // control word sent
    logic [11:0] smp, res_data;             // converter input and result
    logic [2:0]  mux_sel;                   // channel chosen
    logic [3:0]  drv_sw;                    // panel switches
    integer      seed, n_mismatch, num_checks, i, k;
    tac_link_if lnk ();
    tac_dev_end i_tac_dev_end (.LNK(lnk), .RST_N(RST_N), .SAMPLE_VALUE(smp), .PEN_TOUCH(touch),
        .MUX_SEL(mux_sel), .DRV_SW(drv_sw), .REF_DIFF(ref_diff), .BAT_DIV_EN(bat_en),
        .SAMPLE_HOLD(hold), .REF_ON(ref_on), .ADC_ON(adc_on));
    tac_host_end i_tac_host_end (.MCLK(MCLK), .RST_N(RST_N), .LNK(lnk), .CMD_VALID(cmd_valid),
        .CMD_WORD(cmd_word), .CMD_READY(cmd_ready), .RES_VALID(res_valid), .RES_DATA(res_data),
        .PEN_IRQ_N(pen_irq_n));
    tac_sva i_tac_sva (.MCLK(MCLK), .RST_N(RST_N), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .din(lnk.din),
        .dout(lnk.dout), .dout_oe(lnk.dout_oe), .busy(lnk.busy));
    // expected result: 8-bit mode keeps the top bits only
    function automatic logic [11:0] exp_res(input logic [7:0] cw, input logic [11:0] s);
        exp_res = cw[3] ? {4'h0, s[11:4]} : s;
    endfunction : exp_res
    // channels measured across the panel
    function automatic logic panel_ch(input logic [2:0] ch);
        panel_ch = (ch == 3'h1) || (ch == 3'h3) || (ch == 3'h4) || (ch == 3'h5);
    endfunction : panel_ch
    // panel switch pattern {xp, xn, yp, yn} while a channel is acquired
    function automatic logic [3:0] exp_drv(input logic [2:0] ch);
        exp_drv = (ch == 3'h1) ? 4'hc : (ch == 3'h5) ? 4'h3 : (ch == 3'h3 || ch == 3'h4) ? 4'h6 : 4'h0;
    endfunction : exp_drv
    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_flag(input logic got, input logic exp);
        chk_val({11'h000, got}, {11'h000, exp});
    endtask : chk_flag
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    // clock and watchdog
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    initial begin
        #500000;
        n_mismatch++;
        test_done();
    end
    // remember any battery divider activity during a frame
    always @(posedge MCLK) if (bat_en === 1'b1) bat_seen <= 1'b1;
    // main sequence: every channel, random mode and power bits
    initial begin
        seed = 32'h3722; n_mismatch = 0; num_checks = 0; RST_N = 1'b0; cmd_valid = 1'b0;
        cmd_word = 8'h00; smp = 12'h000; touch = 1'b0; bat_seen = 1'b0;
        repeat (20) @(posedge MCLK);
        #1 RST_N = 1'b1;
        for (i = 0; i < 16; i++) begin
            w = 8'($random(seed)); smp = 12'($random(seed)); touch = 1'($random(seed));
            w[6:4] = i[2:0];
            if (i == 0) w = 8'h00;  // start bit left out, host supplies it
            if (i == 15) w = 8'hff; // all bits set
            bat_seen = 1'b0; cmd_valid = 1'b1; cmd_word = w;
            @(posedge MCLK);
            #1 cmd_valid = 1'b0;
            chk_flag(cmd_ready, 1'b0);
            k = 0;
            while (res_valid !== 1'b1 && k < 150) begin
                @(posedge MCLK);
                #1 k++;
                // acquisition: between the falls of clocks 5 and 8
                if (k == 28) begin
                    chk_val({8'h00, drv_sw}, {8'h00, exp_drv(w[6:4])});
                    chk_flag(hold, 1'b0);
                    chk_flag(bat_en, w[6:4] == 3'h2);
                end
                // conversion: fall of clock 12, before any end of conversion
                if (k == 50) begin
                    chk_val({8'h00, drv_sw}, {8'h00, (w[2] ? 4'h0 : exp_drv(w[6:4]))});
                    chk_flag(hold, 1'b1);
                end
            end
            chk_flag(res_valid, 1'b1);
            chk_flag(cmd_ready, 1'b1);
            chk_flag(bat_en, 1'b0);
            chk_flag(hold, 1'b1);
            chk_val(res_data, exp_res(w, smp));
            chk_val({9'h000, mux_sel}, {9'h000, w[6:4]});
            chk_flag(ref_diff, panel_ch(w[6:4]) && !w[2]);
            chk_flag(bat_seen, w[6:4] == 3'h2);
            chk_flag(ref_on, w[1]);
            chk_flag(adc_on, w[0]);
            chk_val({8'h00, drv_sw}, w[0] ? 12'h000 : 12'h001);
            repeat (4) @(posedge MCLK); // gap lets the pen level pass the host synchroniser
            chk_flag(pen_irq_n, w[0] ? !panel_ch(w[6:4]) : !touch);
        end
        test_done();
    end
endmodule : tb_touch_adc_serial_control
